// ===== sevt_pkg.sv
`default_nettype none
package sevt_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_PERIOD  = 8'h00; // time_base_period
  localparam logic [7:0] OFF_COMPARE = 8'h04; // special_event_compare
  localparam logic [7:0] OFF_CON1    = 8'h08; // pwm_output_control_one
  localparam logic [7:0] OFF_COUNT   = 8'h0C; // time base count view
  localparam logic [7:0] OFF_TRIGCNT = 8'h10; // trigger counter view

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int          CNT_W      = 15;      // count field width
  localparam int          DIR_BIT    = 15;      // direction bit position
  localparam logic [15:0] PERIOD_MSK = 16'h7FFF; // period storage bits
  localparam logic [15:0] CON1_MSK   = 16'h0777; // implemented bits
  localparam logic [15:0] RST_VAL    = 16'h0000; // power-on value
  localparam int          MODE_BIT   = 8;       // pair one mode bit
  localparam int          HI_EN_BIT  = 4;       // pair one high enable bit
  localparam int          LO_EN_BIT  = 0;       // pair one low enable bit

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY  = 2'h0;     // okay answer
  localparam logic [1:0]  RESP_SLVE  = 2'h2;     // unmapped answer
endpackage
`default_nettype wire

// ===== sevt_compare.sv
`timescale 1ns/1ns
`default_nettype none
// special event comparator: one-cycle pulse on count and direction match
module sevt_compare #(
  parameter int CNT_W = 15
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [CNT_W-1:0] time_base_count,
  input  wire logic             count_direction_flag,
  input  wire logic [CNT_W-1:0] trigger_compare_value,
  input  wire logic             trigger_direction_select,
  output logic                  trigger_pulse
);
  // ---------------------------------------------------------------
  // match detection
  // ---------------------------------------------------------------
  logic match;      // count and direction equal
  logic match_q;    // match seen last cycle
  logic pulse_d;    // next pulse value
  logic pulse_q;    // registered pulse

  // refuse widths that the 16-bit compare register cannot hold
  if (CNT_W < 1 || CNT_W > 15) begin : g_width_check
    $error("count width out of range");
  end

  // compare both fields
  always_comb begin
    match = (time_base_count == trigger_compare_value) &&
            (count_direction_flag == trigger_direction_select);
    pulse_d = match && !match_q;
  end

  // register the match and the pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      match_q <= match;
      pulse_q <= pulse_d;
    end
  end

  assign trigger_pulse = pulse_q;

  a_pulse_single: assert property (@(posedge aclk) disable iff (!aresetn)
    pulse_q |=> !pulse_q)
    else $error("trigger pulse longer than one cycle");
  a_pulse_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    pulse_q |-> $past(time_base_count) == $past(trigger_compare_value))
    else $error("trigger without count match");
  a_dir_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    pulse_q |->
      $past(count_direction_flag) == $past(trigger_direction_select))
    else $error("trigger with wrong direction");
  a_match_fires: assert property (@(posedge aclk) disable iff (!aresetn)
    (match && !match_q) |=> pulse_q)
    else $error("match without trigger");
endmodule
`default_nettype wire

// ===== sevt_top.sv
`timescale 1ns/1ns
`default_nettype none
module sevt_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [sevt_pkg::CNT_W-1:0] time_base_count,
  input  wire logic                       count_direction_flag,
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [15:0]                     period_value,
  output logic                            special_event_trigger,
  output logic                            pair_one_output_mode,
  output logic                            pair_one_high_output_enable,
  output logic                            pair_one_low_output_enable
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0] period_q, period_d;   // time_base_period
  logic [15:0] compare_q, compare_d; // special_event_compare
  logic [15:0] con1_q, con1_d;       // pwm_output_control_one
  logic [15:0] tcnt_q, tcnt_d;       // triggers issued, wraps
  logic        trig_raw;             // pulse from comparator
  logic        trig_q;               // registered trigger output

  // ---------------------------------------------------------------
  // write channel state
  // ---------------------------------------------------------------
  logic        aw_have_q, aw_have_d; // write address held
  logic        w_have_q, w_have_d;   // write data held
  logic [7:0]  awaddr_q, awaddr_d;   // held write address
  logic [31:0] wdata_q, wdata_d;     // held write data
  logic [3:0]  wstrb_q, wstrb_d;     // held byte enables
  logic        bvalid_q, bvalid_d;   // write answer pending
  logic [1:0]  bresp_q, bresp_d;     // write answer code

  // ---------------------------------------------------------------
  // read channel state
  // ---------------------------------------------------------------
  logic        rvalid_q, rvalid_d;   // read answer pending
  logic [31:0] rdata_q, rdata_d;     // read answer data
  logic [1:0]  rresp_q, rresp_d;     // read answer code

  // mapped address check, used by both channels
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == sevt_pkg::OFF_PERIOD)  ||
              (a == sevt_pkg::OFF_COMPARE) ||
              (a == sevt_pkg::OFF_CON1)    ||
              (a == sevt_pkg::OFF_COUNT)   ||
              (a == sevt_pkg::OFF_TRIGCNT);
  endfunction

  // merge byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    merge = old;
    if (st[0]) begin
      merge[7:0] = wd[7:0];
    end
    if (st[1]) begin
      merge[15:8] = wd[15:8];
    end
  endfunction

  // ---------------------------------------------------------------
  // write path next state
  // ---------------------------------------------------------------
  logic do_write; // both halves present, answer slot free
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    period_d  = period_q;
    compare_d = compare_q;
    con1_d    = con1_q;
    // capture address
    if (s_axi_awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    // capture data
    if (s_axi_wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    // answer retired
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // one answer at a time: a new write waits until bready retires it
    do_write = aw_have_q && w_have_q && !bvalid_q;
    // perform the write
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = addr_ok(awaddr_q) ? sevt_pkg::RESP_OKAY
                                    : sevt_pkg::RESP_SLVE;
      case (awaddr_q)
        sevt_pkg::OFF_PERIOD: begin
          period_d = merge(period_q, wdata_q, wstrb_q)
                     & sevt_pkg::PERIOD_MSK;
        end
        sevt_pkg::OFF_COMPARE: begin
          compare_d = merge(compare_q, wdata_q, wstrb_q);
        end
        sevt_pkg::OFF_CON1: begin
          con1_d = merge(con1_q, wdata_q, wstrb_q) & sevt_pkg::CON1_MSK;
        end
        default: begin
          // read-only or unmapped: write ignored
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read path next state
  // ---------------------------------------------------------------
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // accept a read only when no answer is pending
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = addr_ok(s_axi_araddr) ? sevt_pkg::RESP_OKAY
                                       : sevt_pkg::RESP_SLVE;
      // upper half of the word always reads as zero
      rdata_d  = 32'h0000_0000;
      case (s_axi_araddr)
        sevt_pkg::OFF_PERIOD: begin
          rdata_d[15:0] = period_q & sevt_pkg::PERIOD_MSK;
        end
        sevt_pkg::OFF_COMPARE: begin
          rdata_d[15:0] = compare_q;
        end
        sevt_pkg::OFF_CON1: begin
          rdata_d[15:0] = con1_q;
        end
        sevt_pkg::OFF_COUNT: begin
          rdata_d[sevt_pkg::DIR_BIT] = count_direction_flag;
          rdata_d[sevt_pkg::CNT_W-1:0] = time_base_count;
        end
        sevt_pkg::OFF_TRIGCNT: begin
          rdata_d[15:0] = tcnt_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // trigger counter next value
  always_comb begin
    tcnt_d = trig_raw ? tcnt_q + 16'h0001 : tcnt_q;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // every register clears on the synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_q  <= sevt_pkg::RST_VAL;
      compare_q <= sevt_pkg::RST_VAL;
      con1_q    <= sevt_pkg::RST_VAL;
      tcnt_q    <= sevt_pkg::RST_VAL;
      trig_q    <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= sevt_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= sevt_pkg::RESP_OKAY;
    end else begin
      period_q  <= period_d;
      compare_q <= compare_d;
      con1_q    <= con1_d;
      tcnt_q    <= tcnt_d;
      trig_q    <= trig_raw;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ---------------------------------------------------------------
  // comparator
  // ---------------------------------------------------------------
  sevt_compare #(
    .CNT_W (sevt_pkg::CNT_W)
  ) u_cmp (
    .aclk                     (aclk),
    .aresetn                  (aresetn),
    .time_base_count          (time_base_count),
    .count_direction_flag     (count_direction_flag),
    .trigger_compare_value    (compare_q[sevt_pkg::CNT_W-1:0]),
    .trigger_direction_select (compare_q[sevt_pkg::DIR_BIT]),
    .trigger_pulse            (trig_raw)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign period_value  = period_q;
  assign special_event_trigger       = trig_q;
  // pair pins mirror their control bits
  assign pair_one_output_mode        = con1_q[sevt_pkg::MODE_BIT];
  assign pair_one_high_output_enable = con1_q[sevt_pkg::HI_EN_BIT];
  assign pair_one_low_output_enable  = con1_q[sevt_pkg::LO_EN_BIT];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_period_top: assert property (@(posedge aclk) disable iff (!aresetn)
    period_q[15] == 1'b0)
    else $error("period top bit stored");
  a_period_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && awaddr_q == sevt_pkg::OFF_PERIOD && wstrb_q == 4'hF)
    |=> period_q == ($past(wdata_q[15:0]) & sevt_pkg::PERIOD_MSK))
    else $error("period write lost");
  a_compare_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && awaddr_q == sevt_pkg::OFF_COMPARE && wstrb_q == 4'hF)
    |=> compare_q == $past(wdata_q[15:0]))
    else $error("compare write lost");
  a_trig_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_raw |=> special_event_trigger)
    else $error("trigger not forwarded");
  a_count_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && !rvalid_q && s_axi_araddr == sevt_pkg::OFF_COUNT)
    |=> rdata_q[15:0] == {$past(count_direction_flag),
                          $past(time_base_count)})
    else $error("count view wrong");
  a_trig_once: assert property (@(posedge aclk) disable iff (!aresetn)
    special_event_trigger |=> !special_event_trigger)
    else $error("trigger held two cycles");
  // period top bit never shows on a read
  a_period_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && !rvalid_q && s_axi_araddr == sevt_pkg::OFF_PERIOD)
    |=> rdata_q[15] == 1'b0)
    else $error("period top bit read as one");
  // count view is read-only: a write there leaves the registers alone
  a_ro_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && awaddr_q == sevt_pkg::OFF_COUNT)
    |=> period_q == $past(period_q) && compare_q == $past(compare_q))
    else $error("write to count view changed a register");
  // each trigger pulse bumps the tally by one
  a_tally_step: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_raw |=> tcnt_q == $past(tcnt_q) + 16'h0001)
    else $error("trigger tally missed a pulse");
endmodule
`default_nettype wire

// ===== sevt_adc_model.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// converter start input model
// ---------------------------------------------------------------
module sevt_adc_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start_conversion,
  output logic [15:0]      starts_q,
  output logic [15:0]      long_q
);
  logic prev_q; // start level seen at the previous edge

  // one conversion per start, plus a tally of cycles a start is held past its first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      starts_q <= 16'h0000;
      long_q   <= 16'h0000;
      prev_q   <= 1'b0;
    end else begin
      prev_q <= start_conversion;
      // a new conversion begins on the first high cycle only
      if (start_conversion && !prev_q) begin
        starts_q <= starts_q + 16'h0001;
      end
      // a start longer than one cycle is a fault of the source
      if (start_conversion && prev_q) begin
        long_q <= long_q + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic        aclk, aresetn, count_direction_flag;
  logic [14:0] time_base_count;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, special_event_trigger;
  logic [15:0] period_value, starts, longs;
  logic        pair_one_output_mode, pair_one_high_output_enable;
  logic        pair_one_low_output_enable;
  int          fails, num_checks;

  sevt_top i_sevt_top (.aclk, .aresetn, .time_base_count,
    .count_direction_flag, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .period_value, .special_event_trigger,
    .pair_one_output_mode, .pair_one_high_output_enable,
    .pair_one_low_output_enable);
  sevt_adc_model i_sevt_adc_model (.aclk, .aresetn,
    .start_conversion(special_event_trigger), .starts_q(starts),
    .long_q(longs));

  // -------------------------------------------------------------
  // bus and compare helpers
  // -------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr_chk(input string what, input logic [7:0] a,
                        input logic [15:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, ah, wh;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      ah = s_axi_awready && !aw_ok;
      wh = s_axi_wready && !w_ok;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      aw_ok = aw_ok || ah;
      w_ok  = w_ok || wh;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    chk({what, " bresp"}, {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  // read: address held until taken, data taken with rvalid
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    chk(what, exp, s_axi_rdata);
    chk({what, " rresp"}, {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // six count values from a start with a step, then park off-match
  task automatic sweep(input string what, input logic [14:0] from,
                       input logic dn, input int step, input int exp);
    logic [15:0] base;
    base = starts;
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      time_base_count      <= from + 15'(i * step);
      count_direction_flag <= dn;
    end
    @(posedge aclk);
    time_base_count <= from - 15'h0100;
    repeat (5) @(posedge aclk);
    chk(what, 32'(exp), {16'h0000, 16'(starts - base)});
    chk({what, " width"}, 32'h0, {16'h0000, longs});
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_period;
    rd_chk("period reset", sevt_pkg::OFF_PERIOD, 0, 2'h0);
    rd_chk("compare reset", sevt_pkg::OFF_COMPARE, 0, 2'h0);
    chk("period port reset", 32'h0, {16'h0000, period_value});
    wr_chk("period all", sevt_pkg::OFF_PERIOD, 16'hFFFF, 2'h0);
    rd_chk("period top", sevt_pkg::OFF_PERIOD, 32'h7FFF, 2'h0);
    chk("period port", 32'h7FFF, {16'h0000, period_value});
    wr_chk("period alt", sevt_pkg::OFF_PERIOD, 16'h5555, 2'h0);
    rd_chk("period alt", sevt_pkg::OFF_PERIOD, 32'h5555, 2'h0);
    // count zero, counting up, meets the reset compare value once
    chk("reset match", 32'h1, {16'h0000, starts});
  endtask

  task automatic t_count_view;
    @(posedge aclk);
    time_base_count      <= 15'h1234;
    count_direction_flag <= 1'b1;
    rd_chk("count view", sevt_pkg::OFF_COUNT, 32'h9234, 2'h0);
    wr_chk("count write", sevt_pkg::OFF_COUNT, 16'h0000, 2'h0);
    rd_chk("count kept", sevt_pkg::OFF_COUNT, 32'h9234, 2'h0);
  endtask

  task automatic t_trigger;
    wr_chk("cmp down", sevt_pkg::OFF_COMPARE, 16'h8010, 2'h0);
    rd_chk("cmp down", sevt_pkg::OFF_COMPARE, 32'h8010, 2'h0);
    sweep("down match", 15'h0012, 1'b1, -1, 1);
    sweep("down vs up", 15'h0012, 1'b0, -1, 0);
    sweep("held match", 15'h0010, 1'b1, 0, 1);
    wr_chk("cmp up", sevt_pkg::OFF_COMPARE, 16'h0010, 2'h0);
    sweep("up match", 15'h000E, 1'b0, 1, 1);
    sweep("up vs down", 15'h000E, 1'b1, 1, 0);
    wr_chk("cmp top", sevt_pkg::OFF_COMPARE, 16'h7FFF, 2'h0);
    sweep("top match", 15'h7FFA, 1'b0, 1, 1);
    // four sweep matches plus the one right after reset
    rd_chk("tally", sevt_pkg::OFF_TRIGCNT, 32'h5, 2'h0);
  endtask

  task automatic t_con1;
    wr_chk("con1 all", sevt_pkg::OFF_CON1, 16'hFFFF, 2'h0);
    rd_chk("con1 all", sevt_pkg::OFF_CON1, 32'h0777, 2'h0);
    chk("pair pins", 32'h7, {29'h0, pair_one_output_mode,
        pair_one_high_output_enable, pair_one_low_output_enable});
    wr_chk("con1 mode", sevt_pkg::OFF_CON1, 16'h0100, 2'h0);
    chk("pair mode", 32'h4, {29'h0, pair_one_output_mode,
        pair_one_high_output_enable, pair_one_low_output_enable});
  endtask

  task automatic t_unmapped;
    rd_chk("hole read", 8'h20, 32'h0, sevt_pkg::RESP_SLVE);
    wr_chk("hole write", 8'h20, 16'hFFFF, sevt_pkg::RESP_SLVE);
  endtask

  // -------------------------------------------------------------
  // verdict, clock, watchdog, main sequence
  // -------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    report_and_stop();
  end

  initial begin
    {aresetn, count_direction_flag, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {time_base_count, s_axi_awaddr, s_axi_araddr} = 31'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    fails = 0;
    num_checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_period();
    t_count_view();
    t_trigger();
    t_con1();
    t_unmapped();
    report_and_stop();
  end
endmodule
`default_nettype wire
